// >>> common/cocr_map.svh
// Register map, field positions, reset values and timing figures
`ifndef COCR_MAP_SVH
`define COCR_MAP_SVH
`define COCR_SMB_CMD 8'h3B
`define COCR_I2C_LO 8'h02
`define COCR_I2C_HI 8'h03
`define COCR_RESET 16'h0211
`define COCR_RW_MASK 16'h1EFF
`define COCR_B_RATIO 12
`define COCR_B_BATTERY_CURRENT_MONITOR 11
`define COCR_B_SYSTEM_POWER_MONITOR 10
`define COCR_B_GAIN 9
`define COCR_B_REF 7
`define COCR_B_POL 6
`define COCR_B_DEG_HI 5
`define COCR_B_DEG_LO 4
`define COCR_B_LATCH 3
`define COCR_B_FORCE 2
`define COCR_B_DISCH 1
`define COCR_B_WAKE 0
`define COCR_MCLK_MHZ 250
`define COCR_DEG_SHORT_US 2
`define COCR_DEG_MID_MS 2
`define COCR_DEG_LONG_S 5
`define COCR_DISCH_MS 40
`define COCR_WAKE_DEG_MIN 1
`define COCR_WAKE_MAX_MIN 30
`endif

// >>> common/cocr_pkg.sv
// Types shared by the charger option control block
package cocr_pkg;
  typedef logic [39:0] cocr_count_t;
  typedef enum logic {COCR_WAKE_IDLE, COCR_WAKE_CHARGE} cocr_wake_t;
  typedef struct packed {
    logic level;
    cocr_count_t count;
  } cocr_deg_state_t;
  typedef struct packed {
    logic done;
    cocr_count_t count;
  } cocr_tmr_state_t;
  typedef struct packed {
    logic [15:0] ctrl;
    logic latch;
    logic fet_off;
    logic cmp_out;
    logic adapter_d;
    cocr_wake_t wake;
    logic [15:0] rdata;
    logic ack;
  } cocr_top_state_t;
endpackage : cocr_pkg

// >>> core/cocr_deglitch.sv
// Level filter: output follows input only after it holds for limit cycles
`timescale 1ns/1ps
`default_nettype none
module cocr_deglitch import cocr_pkg::*; (
  input wire logic mclk,
  input wire logic reset,
  input wire logic enable,
  input wire logic sample,
  input wire cocr_count_t limit,
  output logic level
);
  cocr_deg_state_t s_reg;
  cocr_deg_state_t s_next;

  always_comb begin
    s_next = s_reg;
    if (!enable) begin
      s_next = '0;
    end else if (sample == s_reg.level) begin
      s_next.count = '0;
    end else if (s_reg.count + 40'h1 >= limit) begin
      s_next.level = sample;
      s_next.count = '0;
    end else begin
      s_next.count = s_reg.count + 40'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign level = s_reg.level;
endmodule : cocr_deglitch
`default_nettype wire

// >>> core/cocr_timer.sv
// Interval timer: one-cycle done pulse after run has held for limit cycles
`timescale 1ns/1ps
`default_nettype none
module cocr_timer import cocr_pkg::*; (
  input wire logic mclk,
  input wire logic reset,
  input wire logic run,
  input wire cocr_count_t limit,
  output logic done
);
  cocr_tmr_state_t s_reg;
  cocr_tmr_state_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (!run || s_reg.done) begin
      // Count restarts after each expiry so a re-armed run gets a full span
      s_next.count = '0;
    end else if (s_reg.count + 40'h1 >= limit) begin
      s_next.done = 1'b1;
      s_next.count = '0;
    end else begin
      s_next.count = s_reg.count + 40'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign done = s_reg.done;
endmodule : cocr_timer
`default_nettype wire

// >>> core/cocr_top.sv
// Charger option control register with comparator, discharge and wakeup
`timescale 1ns/1ps
`default_nettype none
`include "cocr_map.svh"
module cocr_top import cocr_pkg::*; #(
  parameter cocr_count_t DEG_MID_CYC =
    40'(64'd`COCR_DEG_MID_MS * 64'd1000 * 64'd`COCR_MCLK_MHZ),
  parameter cocr_count_t DEG_LONG_CYC =
    40'(64'd`COCR_DEG_LONG_S * 64'd1000000 * 64'd`COCR_MCLK_MHZ),
  parameter cocr_count_t DISCH_CYC =
    40'(64'd`COCR_DISCH_MS * 64'd1000 * 64'd`COCR_MCLK_MHZ),
  parameter cocr_count_t WAKE_DEG_CYC =
    40'(64'd`COCR_WAKE_DEG_MIN * 64'd60000000 * 64'd`COCR_MCLK_MHZ),
  parameter cocr_count_t WAKE_MAX_CYC =
    40'(64'd`COCR_WAKE_MAX_MIN * 64'd60000000 * 64'd`COCR_MCLK_MHZ)
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic bus_is_i2c,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_ack,
  input wire logic comparator_input_pin,
  input wire logic adapter_present,
  input wire logic battery_low,
  output logic sense_resistor_ratio,
  output logic battery_current_monitor_en,
  output logic system_power_monitor_en,
  output logic system_power_monitor_gain,
  output logic comparator_reference_select,
  output logic comparator_output_pin,
  output logic power_path_latch_off,
  output logic battery_switch_transistor_off,
  output logic battery_pin_discharge,
  output logic wakeup_charge_en
);
  localparam cocr_count_t DEG_SHORT_CYC =
    40'(64'd`COCR_DEG_SHORT_US * 64'd`COCR_MCLK_MHZ);
  localparam cocr_top_state_t RESET_STATE = '{
    ctrl: `COCR_RESET,
    latch: 1'b0,
    fet_off: 1'b0,
    cmp_out: 1'b1,
    adapter_d: 1'b0,
    wake: COCR_WAKE_IDLE,
    rdata: 16'h0000,
    ack: 1'b0
  };

  // Which part of the word an access reaches: 2'b11 word, 2'b10 high
  // byte, 2'b01 low byte, 2'b00 unmapped
  function automatic logic [1:0] cocr_lanes(input logic i2c,
                                            input logic [7:0] addr);
    logic [1:0] lanes;
    lanes = 2'b00;
    if (!i2c && addr == `COCR_SMB_CMD) begin
      lanes = 2'b11;
    end else if (i2c && addr == `COCR_I2C_HI) begin
      lanes = 2'b10;
    end else if (i2c && addr == `COCR_I2C_LO) begin
      lanes = 2'b01;
    end
    return lanes;
  endfunction : cocr_lanes

  cocr_top_state_t s_reg;
  cocr_top_state_t s_next;
  logic [1:0] lanes;
  logic wr_hit;
  logic rd_hit;
  logic [15:0] wr_word;
  logic [15:0] wr_mask;
  logic adapter_plug;
  logic [1:0] deg_sel;
  cocr_count_t cmp_limit;
  logic cmp_above;
  logic disch_done;
  logic wake_done;
  logic batt_recovered;

  assign lanes = cocr_lanes(bus_is_i2c, reg_addr);
  assign wr_hit = reg_wr && (lanes != 2'b00);
  assign rd_hit = reg_rd && !reg_wr && (lanes != 2'b00);
  assign adapter_plug = adapter_present && !s_reg.adapter_d;
  assign deg_sel = s_reg.ctrl[`COCR_B_DEG_HI:`COCR_B_DEG_LO];

  // Byte accesses carry their data in the low byte of reg_wdata
  always_comb begin
    wr_word = reg_wdata;
    wr_mask = 16'h0000;
    unique case (lanes)
      2'b11: wr_mask = `COCR_RW_MASK;
      2'b10: begin
        wr_word = {reg_wdata[7:0], 8'h00};
        wr_mask = `COCR_RW_MASK & 16'hFF00;
      end
      2'b01: wr_mask = `COCR_RW_MASK & 16'h00FF;
      2'b00: wr_mask = 16'h0000;
    endcase
  end

  always_comb begin
    unique case (deg_sel)
      2'b01: cmp_limit = DEG_SHORT_CYC;
      2'b10: cmp_limit = DEG_MID_CYC;
      2'b11: cmp_limit = DEG_LONG_CYC;
      2'b00: cmp_limit = DEG_SHORT_CYC;
    endcase
  end

  // Filter is held clear while the comparator is disabled
  cocr_deglitch u_cmp_filter (
    .mclk(mclk),
    .reset(reset),
    .enable(deg_sel != 2'b00),
    .sample(comparator_input_pin),
    .limit(cmp_limit),
    .level(cmp_above)
  );

  cocr_timer u_disch_timer (
    .mclk(mclk),
    .reset(reset),
    .run(s_reg.ctrl[`COCR_B_DISCH]),
    .limit(DISCH_CYC),
    .done(disch_done)
  );

  cocr_timer u_wake_timer (
    .mclk(mclk),
    .reset(reset),
    .run(s_reg.wake == COCR_WAKE_CHARGE),
    .limit(WAKE_MAX_CYC),
    .done(wake_done)
  );

  cocr_deglitch u_wake_filter (
    .mclk(mclk),
    .reset(reset),
    .enable(s_reg.wake == COCR_WAKE_CHARGE),
    .sample(!battery_low),
    .limit(WAKE_DEG_CYC),
    .level(batt_recovered)
  );

  always_comb begin
    s_next = s_reg;
    s_next.ack = wr_hit || rd_hit;
    s_next.adapter_d = adapter_present;
    // Hardware clears come first so a host write in the same cycle wins
    if (adapter_plug) begin
      s_next.ctrl[`COCR_B_FORCE] = 1'b0;
    end
    if (disch_done) begin
      s_next.ctrl[`COCR_B_DISCH] = 1'b0;
    end
    if (wake_done) begin
      s_next.ctrl[`COCR_B_WAKE] = 1'b0;
    end
    if (wr_hit) begin
      s_next.ctrl = (s_next.ctrl & ~wr_mask) | (wr_word & wr_mask);
    end
    if (rd_hit) begin
      unique case (lanes)
        2'b10: s_next.rdata = {8'h00, s_reg.ctrl[15:8]};
        2'b01: s_next.rdata = {8'h00, s_reg.ctrl[7:0]};
        default: s_next.rdata = s_reg.ctrl;
      endcase
    end
    // Latch has no clear path: only the power-on reset releases it
    if (cmp_above && s_reg.ctrl[`COCR_B_LATCH]) begin
      s_next.latch = 1'b1;
    end
    s_next.fet_off = s_next.ctrl[`COCR_B_FORCE] || s_next.latch;
    s_next.cmp_out = s_reg.ctrl[`COCR_B_POL] ? cmp_above
                                               : !cmp_above;
    unique case (s_reg.wake)
      COCR_WAKE_IDLE: begin
        if (s_reg.ctrl[`COCR_B_WAKE] && battery_low) begin
          s_next.wake = COCR_WAKE_CHARGE;
        end
      end
      COCR_WAKE_CHARGE: begin
        if (!s_reg.ctrl[`COCR_B_WAKE] || wake_done || batt_recovered) begin
          s_next.wake = COCR_WAKE_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_reg <= RESET_STATE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata = s_reg.rdata;
  assign reg_ack = s_reg.ack;
  assign sense_resistor_ratio = s_reg.ctrl[`COCR_B_RATIO];
  assign battery_current_monitor_en = s_reg.ctrl[`COCR_B_BATTERY_CURRENT_MONITOR];
  assign system_power_monitor_en = s_reg.ctrl[`COCR_B_SYSTEM_POWER_MONITOR];
  assign system_power_monitor_gain = s_reg.ctrl[`COCR_B_GAIN];
  assign comparator_reference_select = s_reg.ctrl[`COCR_B_REF];
  assign comparator_output_pin = s_reg.cmp_out;
  assign power_path_latch_off = s_reg.latch;
  assign battery_switch_transistor_off = s_reg.fet_off;
  assign battery_pin_discharge = s_reg.ctrl[`COCR_B_DISCH];
  assign wakeup_charge_en = s_reg.wake == COCR_WAKE_CHARGE;

  property p_word_write;
    @(posedge mclk) disable iff (reset)
      reg_wr && !bus_is_i2c && reg_addr == `COCR_SMB_CMD |=>
        reg_ack && sense_resistor_ratio == $past(reg_wdata[12]) &&
        system_power_monitor_gain == $past(reg_wdata[9]);
  endproperty
  a_word_write: assert property (p_word_write)
    else $error("word write did not reach control outputs");

  property p_low_byte_keeps_high;
    @(posedge mclk) disable iff (reset)
      reg_wr && bus_is_i2c && reg_addr == `COCR_I2C_LO |=>
        $stable(battery_current_monitor_en) &&
        $stable(system_power_monitor_en);
  endproperty
  a_low_byte_keeps_high: assert property (p_low_byte_keeps_high)
    else $error("low byte write disturbed high byte");

  property p_reserved_zero;
    @(posedge mclk) disable iff (reset)
      reg_ack |-> reg_rdata[15:13] == 3'h0 && reg_rdata[8] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read non-zero");

  property p_high_byte_monitor;
    @(posedge mclk) disable iff (reset)
      reg_wr && bus_is_i2c && reg_addr == `COCR_I2C_HI |=>
        battery_current_monitor_en == $past(reg_wdata[3]) &&
        system_power_monitor_en == $past(reg_wdata[2]);
  endproperty
  a_high_byte_monitor: assert property (p_high_byte_monitor)
    else $error("high byte write did not set monitor enables");

  property p_polarity;
    @(posedge mclk) disable iff (reset)
      deg_sel != 2'b00 && cmp_above ##1 $stable(s_reg.ctrl[`COCR_B_POL]) |->
        comparator_output_pin == s_reg.ctrl[`COCR_B_POL];
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("comparator output polarity wrong");

  property p_disabled_quiet;
    @(posedge mclk) disable iff (reset)
      deg_sel == 2'b00 ##1 deg_sel == 2'b00 |-> !cmp_above;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("disabled comparator reported a trip");

  property p_latch_on_trip;
    @(posedge mclk) disable iff (reset)
      cmp_above && s_reg.ctrl[`COCR_B_LATCH] |=>
        power_path_latch_off ##1 battery_switch_transistor_off;
  endproperty
  a_latch_on_trip: assert property (p_latch_on_trip)
    else $error("trip did not latch the power path off");

  property p_latch_holds;
    @(posedge mclk) disable iff (reset)
      power_path_latch_off |=> power_path_latch_off;
  endproperty
  a_latch_holds: assert property (p_latch_holds)
    else $error("power path latch released without reset");

  property p_plug_clears_force;
    @(posedge mclk) disable iff (reset)
      adapter_plug && !reg_wr |=> !s_reg.ctrl[`COCR_B_FORCE];
  endproperty
  a_plug_clears_force: assert property (p_plug_clears_force)
    else $error("adapter plug-in did not clear force bit");

  property p_disch_clear;
    @(posedge mclk) disable iff (reset)
      disch_done && !reg_wr |=> !battery_pin_discharge;
  endproperty
  a_disch_clear: assert property (p_disch_clear)
    else $error("discharge bit not cleared at interval end");

  property p_wake_start;
    @(posedge mclk) disable iff (reset)
      s_reg.wake == COCR_WAKE_IDLE && s_reg.ctrl[`COCR_B_WAKE] &&
        battery_low |=> wakeup_charge_en;
  endproperty
  a_wake_start: assert property (p_wake_start)
    else $error("wakeup charge did not start");

  property p_wake_expiry;
    @(posedge mclk) disable iff (reset)
      wake_done && !reg_wr |=> !wakeup_charge_en &&
        !s_reg.ctrl[`COCR_B_WAKE];
  endproperty
  a_wake_expiry: assert property (p_wake_expiry)
    else $error("wakeup expiry did not stop charge and clear bit");

  property p_disch_start;
    @(posedge mclk) disable iff (reset)
      reg_wr && !bus_is_i2c && reg_addr == `COCR_SMB_CMD &&
        reg_wdata[`COCR_B_DISCH] |=> battery_pin_discharge;
  endproperty
  a_disch_start: assert property (p_disch_start)
    else $error("discharge write did not start discharge");

  property p_wake_recover;
    @(posedge mclk) disable iff (reset)
      wakeup_charge_en && batt_recovered |=> !wakeup_charge_en;
  endproperty
  a_wake_recover: assert property (p_wake_recover)
    else $error("wakeup charge ran on after recovery");
endmodule : cocr_top
`default_nettype wire

// >>> bench/cocr_host_model.sv
// Host bus master model for the option register access strobes
`timescale 1ns/1ps
`default_nettype none
module cocr_host_model (
  input wire logic mclk,
  output logic bus_is_i2c,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_ack
);
  initial begin
    bus_is_i2c = 1'b0;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end
  // Strobe lasts one cycle; the answer is taken in the cycle after
  task automatic access(input logic i2c, input logic wr, input logic [7:0] a,
      input logic [15:0] d, output logic [15:0] q, output logic ok);
    @(negedge mclk);
    bus_is_i2c = i2c;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = wr;
    reg_rd = !wr;
    @(negedge mclk);
    ok = reg_ack;
    q = reg_rdata;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // Released address and data lines never keep the last value
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : access
endmodule : cocr_host_model
`default_nettype wire

// >>> bench/test_cocr_top.sv
// Self-checking bench for the charger option control register
`timescale 1ns/1ps
`default_nettype none
`include "cocr_map.svh"
`define CHK(act, exp, msg) begin samples_checked++; \
  if ((act) !== (exp)) begin n_fail++; \
  $display("mismatch at %0t: %s", $time, msg); end end
module test_cocr_top import cocr_pkg::*;;
  localparam logic [7:0] CMD = `COCR_SMB_CMD;
  localparam int SHORT = 500;
  localparam int MID = 20;
  localparam int LONG = 40;
  localparam int DIS = 30;
  localparam int WDEG = 25;
  localparam int WMAX = 100;
  logic mclk, reset, bus_is_i2c, reg_wr, reg_rd, reg_ack;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic comparator_input_pin, adapter_present, battery_low;
  logic sense_resistor_ratio, battery_current_monitor_en;
  logic system_power_monitor_en, system_power_monitor_gain;
  logic comparator_reference_select, comparator_output_pin;
  logic power_path_latch_off, battery_switch_transistor_off;
  logic battery_pin_discharge, wakeup_charge_en;
  logic [4:0] dir;
  int n_fail = 0;
  int samples_checked = 0;
  int lim;
  assign dir = {sense_resistor_ratio, battery_current_monitor_en,
    system_power_monitor_en, system_power_monitor_gain,
    comparator_reference_select};
  cocr_top #(.DEG_MID_CYC(40'(MID)), .DEG_LONG_CYC(40'(LONG)),
    .DISCH_CYC(40'(DIS)), .WAKE_DEG_CYC(40'(WDEG)),
    .WAKE_MAX_CYC(40'(WMAX))) i_cocr_top (.mclk(mclk), .reset(reset),
    .bus_is_i2c(bus_is_i2c), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .comparator_input_pin(comparator_input_pin),
    .adapter_present(adapter_present), .battery_low(battery_low),
    .sense_resistor_ratio(sense_resistor_ratio),
    .battery_current_monitor_en(battery_current_monitor_en),
    .system_power_monitor_en(system_power_monitor_en),
    .system_power_monitor_gain(system_power_monitor_gain),
    .comparator_reference_select(comparator_reference_select),
    .comparator_output_pin(comparator_output_pin),
    .power_path_latch_off(power_path_latch_off),
    .battery_switch_transistor_off(battery_switch_transistor_off),
    .battery_pin_discharge(battery_pin_discharge),
    .wakeup_charge_en(wakeup_charge_en));
  cocr_host_model i_cocr_host_model (.mclk(mclk), .bus_is_i2c(bus_is_i2c),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  task automatic do_reset();
    reset = 1'b1;
    cyc(20);
    reset = 1'b0;
  endtask : do_reset
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
      input logic i2c, input logic okx);
    logic [15:0] q;
    logic ok;
    i_cocr_host_model.access(i2c, 1'b1, a, d, q, ok);
    `CHK(ok, okx, "write acknowledge")
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e,
      input logic i2c, input logic okx);
    logic [15:0] q;
    logic ok;
    i_cocr_host_model.access(i2c, 1'b0, a, 16'h0000, q, ok);
    `CHK(ok, okx, "read acknowledge")
    if (okx) `CHK(q, e, "read data")
  endtask : rd
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    give_verdict();
  end
  initial begin
    reset = 1'b1;
    comparator_input_pin = 1'b0;
    adapter_present = 1'b0;
    battery_low = 1'b0;
    do_reset();
    rd(CMD, `COCR_RESET, 1'b0, 1'b1);
    `CHK(dir, 5'b00010, "default controls")
    `CHK(comparator_output_pin, 1'b1, "default compare out")
    $display("test defaults done");
    wr(CMD, 16'hFFFF, 1'b0, 1'b1);
    rd(CMD, 16'hFFFF & `COCR_RW_MASK, 1'b0, 1'b1);
    `CHK(dir, 5'b11111, "controls set")
    wr(CMD, 16'h0000, 1'b0, 1'b1);
    `CHK(dir, 5'b00000, "controls clear")
    wr(8'h3C, 16'hFFFF, 1'b0, 1'b0);
    wr(`COCR_I2C_LO, 16'hFFFF, 1'b0, 1'b0);
    wr(`COCR_I2C_HI, 16'h00FF, 1'b1, 1'b1);
    wr(`COCR_I2C_LO, 16'h00C0, 1'b1, 1'b1);
    wr(8'h04, 16'hFFFF, 1'b1, 1'b0);
    wr(CMD, 16'hFFFF, 1'b1, 1'b0);
    rd(`COCR_I2C_HI, 16'h001E, 1'b1, 1'b1);
    rd(`COCR_I2C_LO, 16'h00C0, 1'b1, 1'b1);
    rd(CMD, 16'h1EC0, 1'b0, 1'b1);
    `CHK(comparator_reference_select, 1'b1, "reference select")
    $display("test map done");
    // Every deglitch code with both polarities
    for (int i = 0; i < 8; i++) begin
      lim = (i[1:0] == 2'd1) ? SHORT : (i[1:0] == 2'd2) ? MID : LONG;
      wr(CMD, {9'h000, i[2], i[1:0], 4'h0}, 1'b0, 1'b1);
      comparator_input_pin = 1'b1;
      cyc(lim - 3);
      `CHK(comparator_output_pin, !i[2], "output before deglitch")
      cyc(6);
      `CHK(comparator_output_pin, (i[1:0] == 2'd0) ^ i[2], "tripped")
      comparator_input_pin = 1'b0;
      cyc(lim + 5);
      `CHK(comparator_output_pin, !i[2], "released")
      `CHK(power_path_latch_off, 1'b0, "no latch")
    end
    $display("test comparator done");
    wr(CMD, 16'h0018, 1'b0, 1'b1);
    comparator_input_pin = 1'b1;
    cyc(SHORT + 10);
    `CHK(power_path_latch_off, 1'b1, "latch set")
    `CHK(battery_switch_transistor_off, 1'b1, "switch latched")
    comparator_input_pin = 1'b0;
    wr(CMD, 16'h0000, 1'b0, 1'b1);
    cyc(SHORT + 10);
    `CHK(power_path_latch_off, 1'b1, "latch held")
    do_reset();
    `CHK(power_path_latch_off, 1'b0, "latch cleared")
    $display("test latch done");
    wr(CMD, 16'h0004, 1'b0, 1'b1);
    cyc(2);
    `CHK(battery_switch_transistor_off, 1'b1, "forced off")
    adapter_present = 1'b1;
    cyc(3);
    rd(CMD, 16'h0000, 1'b0, 1'b1);
    `CHK(battery_switch_transistor_off, 1'b0, "force cleared")
    $display("test force done");
    wr(CMD, 16'h0002, 1'b0, 1'b1);
    `CHK(battery_pin_discharge, 1'b1, "discharge on")
    cyc(DIS - 5);
    `CHK(battery_pin_discharge, 1'b1, "discharge runs")
    cyc(10);
    `CHK(battery_pin_discharge, 1'b0, "discharge ended")
    rd(CMD, 16'h0000, 1'b0, 1'b1);
    $display("test discharge done");
    wr(CMD, 16'h0001, 1'b0, 1'b1);
    battery_low = 1'b1;
    cyc(2);
    `CHK(wakeup_charge_en, 1'b1, "wakeup start")
    battery_low = 1'b0;
    cyc(WDEG - 5);
    `CHK(wakeup_charge_en, 1'b1, "wakeup deglitch")
    cyc(10);
    `CHK(wakeup_charge_en, 1'b0, "wakeup stop")
    battery_low = 1'b1;
    cyc(2);
    `CHK(wakeup_charge_en, 1'b1, "wakeup restart")
    cyc(WMAX - 10);
    `CHK(wakeup_charge_en, 1'b1, "wakeup before expiry")
    cyc(15);
    `CHK(wakeup_charge_en, 1'b0, "wakeup expired")
    rd(CMD, 16'h0000, 1'b0, 1'b1);
    $display("test wakeup done");
    give_verdict();
  end
endmodule : test_cocr_top
`default_nettype wire
